// ==== design/codec_power_sleep_control.sv ====
// Power-down, standby and sleep control of the codec, with its
// link-facing framer on the bit clock.
// Assumes the controller drives sync and sdata_out on bit_clk.
//
// Contract
// (R1) converter-ready status bit 0 reads as inverse of input converter power-down.
// (R2) strap high during reset powers down every main power-down block.
// (R3) strap changes only the main power register reset value.
// (R4) extended bits 15..11 power down oscillator and four converters; reset 0.
// (R5) extended bits 10..7 disable mic bias, hp mixers and speaker mixer.
// (R6) extended bits 6..3 disable mono, third, headphone and speaker outputs.
// (R7) extended bits 2..0 disable line, phone and mic input amplifiers.
// (R8) software mutes an input amplifier before powering it down.
// (R9) link power-down bit disables the link and enters sleep.
// (R10) gpio, interrupts, comparators and analogue paths keep working asleep.
// (R11) warm reset on the link wakes the device.
// (R12) gpio event wakes only if pin is input and wake-enabled.
// (R13) a virtual gpio event wakes the device.
// (R14) all power-down bits set gives low-power standby, reference string kept.
// (R15) additional bit 10 disconnects the standby reference string; reset 0.
// (R16) bias field 6:5, reset 11, selects analogue bias current.
// (R17) bit clock normally from own oscillator, external generator accepted.
// (R18) controller generates frame sync.
// (R19) each direction carries 256-bit frames of 13 slots.
// (R20) frames repeat at 48 kHz.
// (R21) controller holds data out and sync low through reset.
// (R22) sync high about 1.3 us each frame, period about 20.8 us.
// (R23) a block is on only when both its control bits are zero.
// (R24) main bit 12 powers down the link including the bit clock.
// (R25) bit clock and data in low within 1.0 us after slot 2.
// (R26) a wake restarts oscillator and bit clock.
`default_nettype none
`include "codec_pwr_cfg.svh"
module codec_power_sleep_control
    import codec_pwr_pkg::*;
(
    input wire logic core_clk, // core clock, 250 MHz
    input wire logic rst, // asynchronous reset, high
    input wire logic bit_clk, // link bit clock
    input wire logic sync, // frame sync from controller
    input wire logic sdata_out, // serial data from controller
    output logic sdata_in, // serial data to controller
    input wire logic power_default_strap, // strap pin, high = all off
    input wire logic ext_clk_sel, // pin, high = bit clock from outside
    input wire logic [4:0] gpio_level, // gpio pins, active level high
    input wire logic [4:0] gpio_is_input, // gpio configured as input
    input wire logic [4:0] gpio_wake_en, // gpio wake-up enable
    input wire logic [2:0] vgpio_event, // internal virtual gpio events
    output logic [15:0] block_on, // per extended bit, block powered
    output logic link_sleep, // link powered down, device asleep
    output logic bit_clk_oe, // drive bit clock pin to controller
    output logic osc_run, // crystal oscillator enabled
    output logic standby, // low-power standby reached
    output logic vref_string_on, // standby reference string connected
    output logic [1:0] bias_sel // analogue bias current select
);
    typedef struct packed {
        core_mode_e mode;
        logic [1:0] hold;
        logic strap_s1;
        logic strap_s2;
        logic ext_s1;
        logic ext_s2;
        logic sync_s1;
        logic sync_s2;
        logic [4:0] gp_s1;
        logic [4:0] gp_s2;
        logic [2:0] vg_s1;
        logic [2:0] vg_s2;
        logic wr_s1;
        logic wr_s2;
        logic wr_q;
        logic rd_s1;
        logic rd_s2;
        logic rd_q;
        logic rd_ack;
        logic [15:0] rd_data;
        logic [7:0] pwr;
        logic [15:0] ext;
        logic [15:0] af;
        logic [15:0] afc;
        logic run;
    } core_s;

    core_s r;
    core_s n;
    logic wr_ev;
    logic rd_ev;
    logic wake;
    logic [3:0] ready;
    logic [47:0] map;

    link_if lnk();

    // ==========================================================
    // link side, on the bit clock
    link_framer link_framer_i (
        .bit_clk(bit_clk),
        .rst(rst),
        .sync(sync),
        .sdata_out(sdata_out),
        .sdata_in(sdata_in),
        .lnk(lnk)
    );

    // ==========================================================
    // core state
    always_comb begin
        n = r;
        wake = 1'b0;
        n.strap_s1 = power_default_strap;
        n.strap_s2 = r.strap_s1;
        n.ext_s1 = ext_clk_sel;
        n.ext_s2 = r.ext_s1;
        n.sync_s1 = sync;
        n.sync_s2 = r.sync_s1;
        n.gp_s1 = gpio_level;
        n.gp_s2 = r.gp_s1;
        n.vg_s1 = vgpio_event;
        n.vg_s2 = r.vg_s1;
        n.wr_s1 = lnk.wr_tgl;
        n.wr_s2 = r.wr_s1;
        n.wr_q = r.wr_s2;
        n.rd_s1 = lnk.rd_tgl;
        n.rd_s2 = r.rd_s1;
        n.rd_q = r.rd_s2;
        wr_ev = r.wr_s2 != r.wr_q;
        rd_ev = r.rd_s2 != r.rd_q;
        // status bits 1:0 read as inverse of the matching control bits; bit 3 inverts PR_MIX, bit 2 inverts PR_VREF
        ready = {!r.pwr[`PR_MIX], !r.pwr[`PR_VREF],
                 !r.pwr[`PR_DAC], !r.pwr[`PR_ADC]}; // R1
        case (r.mode)
            CORE_LOAD: begin
                // strap held through release, settled by the sync chain
                n.pwr = r.strap_s2 ? `PWR_RST_STRAP : `PWR_RST_NORMAL; // R2 R3
                n.hold = r.hold + 2'h1;
                if (r.hold == `STRAP_HOLD) begin
                    n.mode = CORE_RUN;
                end
            end
            CORE_RUN: begin
                if (wr_ev) begin
                    case (lnk.wr_addr)
                        `ADDR_EXT_PD: begin
                            n.ext = lnk.wr_data; // R4 R5 R6 R7
                        end
                        `ADDR_PWR_STAT: begin
                            n.pwr = lnk.wr_data[15:8]; // R9
                        end
                        `ADDR_ADD_FUNC: begin
                            n.af = (r.af & ~`AF_WMASK)
                                 | (lnk.wr_data & `AF_WMASK); // R15
                        end
                        `ADDR_ANA_FUNC: begin
                            n.afc = lnk.wr_data; // R16
                        end
                        default: begin
                            n.afc = r.afc;
                        end
                    endcase
                end
                if (n.pwr[`PR_LINK]) begin
                    n.mode = CORE_SLEEP; // R9
                end
            end
            CORE_SLEEP: begin
                // wake sources need no bit clock, only the core clock
                wake = r.sync_s2 // R10 R11
                    || (r.af[`AF_WAKEEN]
                        && |(r.gp_s2 & gpio_is_input & gpio_wake_en)) // R12
                    || |r.vg_s2; // R13
                if (wake) begin
                    n.pwr[`PR_LINK] = 1'b0;
                    n.pwr[`PR_CLK] = 1'b0; // R26
                    n.ext[`EXT_OSC] = 1'b0; // R26
                    n.mode = CORE_RUN;
                end
            end
            default: begin
                n.mode = CORE_LOAD;
            end
        endcase
        // bit clock stops with the link or the oscillator; held off while the
        // strap is still settling so a strapped-off part never pulses it
        n.run = (n.mode != CORE_LOAD) && !n.pwr[`PR_LINK] && !n.ext[`EXT_OSC]; // R2 R24 R26
        if (rd_ev) begin
            n.rd_ack = !r.rd_ack;
            case (lnk.rd_addr)
                `ADDR_EXT_PD: begin
                    n.rd_data = r.ext;
                end
                `ADDR_PWR_STAT: begin
                    n.rd_data = {r.pwr, 4'h0, ready}; // R1
                end
                `ADDR_ADD_FUNC: begin
                    n.rd_data = r.af;
                end
                `ADDR_ANA_FUNC: begin
                    n.rd_data = r.afc;
                end
                default: begin
                    n.rd_data = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.ext <= `EXT_RST; // R4
            r.af <= `AF_RST; // R15
            r.afc <= `AFC_RST; // R16
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // block enables
    assign map = `EXT_MAIN_MAP;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_block
            assign block_on[gi] = !r.ext[gi]
                                && !r.pwr[map[gi*3 +: 3]]; // R23
        end
    endgenerate

    // ==========================================================
    // outputs
    assign lnk.rd_ack = r.rd_ack;
    assign lnk.rd_data = r.rd_data;
    assign lnk.sleep = r.pwr[`PR_LINK];
    assign link_sleep = r.pwr[`PR_LINK]; // R9
    // external generator: pin is never driven by us
    assign bit_clk_oe = r.run && !r.ext_s2; // R17 R24
    assign osc_run = !r.ext[`EXT_OSC]; // R4
    assign standby = (&r.ext) && (&r.pwr); // R14
    assign vref_string_on = !r.af[`AF_SVD]; // R14 R15
    assign bias_sel = r.afc[`AFC_BIAS_HI:`AFC_BIAS_LO]; // R16
endmodule : codec_power_sleep_control
`default_nettype wire

// ==== design/link_framer.sv ====
// Link-side frame logic on the bit clock: decodes register commands,
// returns read data, silences the data output on link power-down.
// Assumes sync and sdata_out change on bit_clk, so no synchroniser.
`default_nettype none
module link_framer
    import codec_pwr_pkg::*;
(
    input wire logic bit_clk, // link bit clock
    input wire logic rst, // asynchronous reset, high
    input wire logic sync, // frame sync from controller
    input wire logic sdata_out, // serial data from controller
    output logic sdata_in, // serial data to controller
    link_if.framer lnk // register traffic to the core
);
    link_s r;
    link_s n;
    logic rise;
    logic bitv;
    logic [55:0] frame;

    // ==========================================================
    // frame decode and response
    always_comb begin
        n = r;
        rise = sync && !r.sync_q;
        frame = {r.rsp_valid, r.rsp_valid, r.rsp_valid, 13'h0000,
                 1'b0, r.rsp_addr, 12'h000, r.rsp_data, 4'h0};
        n.sync_q = sync;
        n.pos = rise ? 8'h00 : r.pos + 8'h01; // R19 R20
        n.shin = {r.shin[38:0], sdata_out};
        n.slp_s1 = lnk.sleep;
        n.slp_s2 = r.slp_s1;
        n.ack_s1 = lnk.rd_ack;
        n.ack_s2 = r.ack_s1;
        n.ack_q = r.ack_s2;
        if (n.pos == `TAG_S1_POS) begin
            n.s1_ok = sdata_out;
        end
        if (n.pos == `TAG_S2_POS) begin
            n.s2_ok = sdata_out;
        end
        // a new sync pulse means the link is alive again
        if (rise) begin
            n.pd_wr = 1'b0;
        end
        if (n.pos == `SLOT2_END && r.s1_ok) begin
            if (n.shin[39]) begin
                n.rd_tgl = !r.rd_tgl;
                n.rd_addr = n.shin[38:32];
            end else if (r.s2_ok) begin
                n.wr_tgl = !r.wr_tgl;
                n.wr_addr = n.shin[38:32];
                n.wr_data = n.shin[19:4];
                if (n.shin[38:32] == `ADDR_PWR_STAT && n.shin[16]) begin
                    n.pd_wr = 1'b1; // R25
                end
            end
        end
        if (rise) begin
            bitv = frame[55];
            n.shout = {frame[54:0], 1'b0};
            n.rsp_valid = 1'b0;
        end else begin
            bitv = r.shout[55];
            n.shout = {r.shout[54:0], 1'b0};
        end
        if (r.ack_s2 != r.ack_q) begin
            n.rsp_valid = 1'b1;
            n.rsp_addr = r.rd_addr;
            n.rsp_data = lnk.rd_data;
        end
        n.sdin = bitv && !n.pd_wr && !r.slp_s2; // R24 R25
    end

    always_ff @(posedge bit_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sdata_in = r.sdin;
    assign lnk.wr_tgl = r.wr_tgl;
    assign lnk.wr_addr = r.wr_addr;
    assign lnk.wr_data = r.wr_data;
    assign lnk.rd_tgl = r.rd_tgl;
    assign lnk.rd_addr = r.rd_addr;
endmodule : link_framer
`default_nettype wire

// ==== pkg/codec_pwr_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the
// codec power and sleep control block.
// Assumes inclusion by bare name from package and design files.
`ifndef CODEC_PWR_CFG_SVH
`define CODEC_PWR_CFG_SVH
// ==========================================================
// register addresses as carried in link slot 1
`define ADDR_EXT_PD 7'h24
`define ADDR_PWR_STAT 7'h26
`define ADDR_ADD_FUNC 7'h58
`define ADDR_ANA_FUNC 7'h5C
// ==========================================================
// main power register: control byte holds bits 15:8
`define PR_ADC 0
`define PR_DAC 1
`define PR_MIX 2
`define PR_VREF 3
`define PR_LINK 4
`define PR_CLK 5
`define PR_HP 6
`define PWR_RST_NORMAL 8'h00
`define PWR_RST_STRAP 8'hFF
// ==========================================================
// extended, additional and analogue function registers
`define EXT_OSC 15
`define EXT_RST 16'h0000
`define AF_SVD 10
`define AF_WAKEEN 1
`define AF_RST 16'h0008
`define AF_WMASK 16'h0403
`define AFC_BIAS_HI 6
`define AFC_BIAS_LO 5
`define AFC_RST 16'h0060
// main-register control bit gating each extended bit, 3 bits each
`define EXT_MAIN_MAP 48'hA480D24B6400
// ==========================================================
// link frame positions, bit 0 is the sync rising bit
`define FRAME_BITS 256
`define TAG_S1_POS 8'h01
`define TAG_S2_POS 8'h02
`define SLOT2_END 8'h37
// ==========================================================
// timing
`define CORE_CLK_PS 4000
`define S2_PDOWN_PS 1000000
`define S2_PDOWN_CYC (`S2_PDOWN_PS / `CORE_CLK_PS)
`define STRAP_HOLD 2'h2
`endif

// ==== pkg/codec_pwr_pkg.sv ====
// Types shared by the power control core and the link framer.
// Assumes codec_pwr_cfg.svh is on the include path.
`default_nettype none
`include "codec_pwr_cfg.svh"
package codec_pwr_pkg;
    typedef enum logic [1:0] {CORE_LOAD, CORE_RUN, CORE_SLEEP} core_mode_e;

    typedef struct packed {
        logic [7:0] pos;
        logic sync_q;
        logic [39:0] shin;
        logic s1_ok;
        logic s2_ok;
        logic [55:0] shout;
        logic sdin;
        logic pd_wr;
        logic slp_s1;
        logic slp_s2;
        logic wr_tgl;
        logic [6:0] wr_addr;
        logic [15:0] wr_data;
        logic rd_tgl;
        logic [6:0] rd_addr;
        logic ack_s1;
        logic ack_s2;
        logic ack_q;
        logic rsp_valid;
        logic [6:0] rsp_addr;
        logic [15:0] rsp_data;
    } link_s;
endpackage : codec_pwr_pkg
`default_nettype wire

// ==== pkg/link_if.sv ====
// Register traffic between the link framer and the power core.
// Words are held stable around each toggle, so only toggles need syncing.
`default_nettype none
interface link_if;
    logic wr_tgl;
    logic [6:0] wr_addr;
    logic [15:0] wr_data;
    logic rd_tgl;
    logic [6:0] rd_addr;
    logic rd_ack;
    logic [15:0] rd_data;
    logic sleep;
    modport framer(output wr_tgl, wr_addr, wr_data, rd_tgl, rd_addr,
                   input rd_ack, rd_data, sleep);
    modport core(input wr_tgl, wr_addr, wr_data, rd_tgl, rd_addr,
                 output rd_ack, rd_data, sleep);
endinterface : link_if
`default_nettype wire

// ==== testbench/codec_power_sleep_control_tb.sv ====
// Self-checking bench for the codec power and sleep control block.
// Assumes link_ctrl_model as controller and the bound checker.
`default_nettype none
module codec_power_sleep_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic bit_clk = 1'b0;
    logic rst = 1'b1;
    logic power_default_strap = 1'b0;
    logic ext_clk_sel = 1'b0;
    logic [4:0] gpio_level = 5'h00;
    logic [4:0] gpio_is_input = 5'h00;
    logic [4:0] gpio_wake_en = 5'h00;
    logic [2:0] vgpio_event = 3'h0;
    logic sync, sdata_out, sdata_in, link_sleep, bit_clk_oe, osc_run, standby, vref_string_on;
    logic [15:0] block_on;
    logic [1:0] bias_sel;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 core_clk = ~core_clk;
    always #16 bit_clk = ~bit_clk;
    codec_power_sleep_control codec_power_sleep_control_i (.core_clk, .rst, .bit_clk, .sync,
        .sdata_out, .sdata_in, .power_default_strap, .ext_clk_sel, .gpio_level,
        .gpio_is_input, .gpio_wake_en, .vgpio_event, .block_on, .link_sleep, .bit_clk_oe,
        .osc_run, .standby, .vref_string_on, .bias_sel);
    link_ctrl_model link_ctrl_model_i (.bit_clk, .sdata_in, .sync, .sdata_out);
    // =====
    function automatic logic [22:0] st();
        return {block_on, link_sleep, osc_run, bit_clk_oe, standby, vref_string_on, bias_sel};
    endfunction : st
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : settle
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        link_ctrl_model_i.frame(1'b1, 1'b0, a, d);
    endtask : wr
    // answer comes back in the frame after the request
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        link_ctrl_model_i.frame(1'b1, 1'b1, a, 16'h0000);
        link_ctrl_model_i.frame(1'b0, 1'b0, 7'h00, 16'h0000);
        check({link_ctrl_model_i.rx[19:25], link_ctrl_model_i.rx[38:53]}, {a, e});
    endtask : rd
    task automatic vg_wake();
        @(posedge core_clk);
        vgpio_event <= 3'h4;
        for (int i = 0; i < 40 && link_sleep !== 1'b0; i++) @(posedge core_clk);
        vgpio_event <= 3'h0;
        settle(4);
    endtask : vg_wake
    // =====
    task automatic t_defaults();
        check(st(), {16'hFFFF, 7'b0110111});
        rd(7'h26, 16'h000F);
        rd(7'h24, 16'h0000);
        rd(7'h58, 16'h0008);
        rd(7'h5C, 16'h0060);
        rd(7'h30, 16'h0000);
        @(posedge core_clk);
        ext_clk_sel <= 1'b1;
        settle(8);
        check(st(), {16'hFFFF, 7'b0100111});
        ext_clk_sel <= 1'b0;
        wr(7'h5C, 16'h0040);
        check(st(), {16'hFFFF, 7'b0110110});
        wr(7'h5C, 16'h0020);
        check(st(), {16'hFFFF, 7'b0110101});
        $display("defaults done");
    endtask : t_defaults
    // each bit gets a distinct code across the patterns
    task automatic t_ext();
        logic [15:0] pat [5] = '{16'hAAAA, 16'hCCCC, 16'hF0F0, 16'hFF00, 16'hFFFF};
        foreach (pat[k]) begin
            // no input drives the amplifiers here, so they count as muted
            wr(7'h24, pat[k]);
            check(st(), {~pat[k], 7'b0000101});
        end
        rd(7'h24, 16'hFFFF);
        wr(7'h24, 16'h0000);
        wr(7'h26, 16'h0100);
        check(st(), {16'hE7F8, 7'b0110101});
        rd(7'h26, 16'h010E);
        wr(7'h26, 16'h0000);
        $display("power bits done");
    endtask : t_ext
    task automatic t_standby();
        wr(7'h58, 16'h0402);
        rd(7'h58, 16'h040A);
        wr(7'h24, 16'hFFFF);
        wr(7'h26, 16'hFF00);
        check(st(), {16'h0000, 7'b1001001});
        vg_wake();
        check(st(), {16'h8000, 7'b0110001});
        $display("standby done");
    endtask : t_standby
    task automatic t_gpio();
        wr(7'h26, 16'h1000);
        @(posedge core_clk);
        gpio_level <= 5'h04;
        gpio_is_input <= 5'h04;
        settle(16);
        check(st(), {16'h8000, 7'b1100001});
        gpio_is_input <= 5'h00;
        gpio_wake_en <= 5'h04;
        settle(16);
        check(st(), {16'h8000, 7'b1100001});
        gpio_is_input <= 5'h04;
        settle(16);
        check(st(), {16'h8000, 7'b0110001});
        gpio_level <= 5'h00;
        wr(7'h26, 16'h1000);
        check(st(), {16'h8000, 7'b1100001});
        link_ctrl_model_i.warm_reset();
        settle(16);
        check(st(), {16'h8000, 7'b0110001});
        rd(7'h26, 16'h000F);
        $display("wake done");
    endtask : t_gpio
    task automatic t_strap();
        @(posedge core_clk);
        rst <= 1'b1;
        power_default_strap <= 1'b1;
        settle(16);
        rst <= 1'b0;
        settle(8);
        check(st(), {16'h0000, 7'b1100111});
        vg_wake();
        check(st(), {16'h8000, 7'b0110111});
        rd(7'h26, 16'hCF00);
        rd(7'h58, 16'h0008);
        $display("strap done");
    endtask : t_strap
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        settle(16);
        rst <= 1'b0;
        settle(8);
        t_defaults();
        t_ext();
        t_standby();
        t_gpio();
        t_strap();
        end_sim();
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 100000) begin
            fails++;
            end_sim();
        end
    end
endmodule : codec_power_sleep_control_tb
`default_nettype wire

// ==== testbench/codec_pwr_monitor.sv ====
// Checker on the ports of the codec power and sleep control top.
// Assumes core_clk with active-high rst; link outputs seen on core_clk.
`default_nettype none
module codec_pwr_monitor (
    input wire logic core_clk, // core clock
    input wire logic rst, // async reset
    input wire logic sdata_in, // data to controller
    input wire logic power_default_strap, // strap pin
    input wire logic ext_clk_sel, // external clock pin
    input wire logic [2:0] vgpio_event, // virtual gpio events
    input wire logic [15:0] block_on, // blocks powered
    input wire logic link_sleep, // asleep
    input wire logic bit_clk_oe, // bit clock driven
    input wire logic osc_run, // oscillator on
    input wire logic standby // standby reached
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // =====
    // strap load window is three edges behind a two-flop sync
    strap_all_off_a: assert property ($fell(rst) && power_default_strap |-> ##6
        block_on == 16'h0000 && link_sleep) else $error("strap high left a block on");
    strap_low_on_a: assert property ($fell(rst) && !power_default_strap |-> ##6
        block_on == 16'hFFFF && !link_sleep) else $error("strap low default wrong");
    standby_off_a: assert property (standby |-> block_on == 16'h0000 && link_sleep)
        else $error("standby with a block on");
    osc_gate_a: assert property (!osc_run && !$past(osc_run) |->
        !block_on[15] && !bit_clk_oe) else $error("oscillator off but clock used");
    sleep_clk_a: assert property (link_sleep && $past(link_sleep) |-> !bit_clk_oe)
        else $error("bit clock driven while asleep");
    sleep_quiet_a: assert property ($rose(link_sleep) |-> !sdata_in [*4])
        else $error("data line not quiet on sleep");
    vgpio_wake_a: assert property ((link_sleep && vgpio_event != 3'h0) [*3] |->
        ##[0:6] !link_sleep) else $error("virtual event did not wake");
    wake_restart_a: assert property ($fell(link_sleep) && !ext_clk_sel |->
        osc_run && bit_clk_oe) else $error("wake did not restart clock");
    ext_clk_a: assert property (ext_clk_sel && $past(ext_clk_sel, 3) |-> !bit_clk_oe)
        else $error("bit clock driven with external clock");
    cover property ($rose(standby));
    cover property ($fell(link_sleep));
    cover property ($rose(link_sleep));
endmodule : codec_pwr_monitor
bind codec_power_sleep_control codec_pwr_monitor codec_pwr_monitor_i (.core_clk, .rst,
    .sdata_in, .power_default_strap, .ext_clk_sel, .vgpio_event, .block_on, .link_sleep,
    .bit_clk_oe, .osc_run, .standby);
`default_nettype wire

// ==== testbench/link_ctrl_model.sv ====
// Controller end of the link: frames register commands, keeps returns.
// Assumes a free-running bit clock from the bench.
`default_nettype none
module link_ctrl_model (
    input wire logic bit_clk, // link bit clock
    input wire logic sdata_in, // serial data from device
    output logic sync, // frame sync to device
    output logic sdata_out // serial data to device
);
    timeunit 1ns;
    timeprecision 100ps;
    // returned bits land two places late: bit p at index p+2
    logic [0:255] rx;
    initial begin
        sync = 1'b0;
        sdata_out = 1'b0;
    end
    // =====
    // one frame; valid and slot tags only when v is set
    task automatic frame(input logic v, input logic rd, input logic [6:0] a,
            input logic [15:0] d);
        logic [0:255] f;
        f = '0;
        f[0:2] = {3{v}};
        f[16:23] = {rd, a};
        f[36:51] = d;
        for (int i = 0; i < 256; i++) begin
            @(posedge bit_clk);
            rx[i] = sdata_in;
            sync <= (i < 16);
            sdata_out <= f[i];
        end
    endtask : frame
    task automatic warm_reset();
        repeat (16) @(posedge bit_clk) sync <= 1'b1;
        @(posedge bit_clk) sync <= 1'b0;
    endtask : warm_reset
endmodule : link_ctrl_model
`default_nettype wire
